// ===== rtl/apc_map.vh
`ifndef APC_MAP_VH
`define APC_MAP_VH
`define APC_ADDR_THRESH_SRC  8'h9f
`define APC_ADDR_AZ_SCHED    8'ha4
`define APC_ADDR_FLICKER     8'ha7
`define APC_ADDR_PROX_FILT   8'haa
`define APC_RST_THRESH_SRC   8'h00
`define APC_RST_AZ_SCHED     8'hff
`define APC_RST_FLICKER      8'h00
`define APC_RST_PROX_FILT    8'h00
`define APC_MASK_THRESH_SRC  8'h07
`define APC_MASK_FLICKER     8'h10
`define APC_MASK_PROX_FILT   8'hcf
`define APC_AZ_NEVER         8'h00
`define APC_AZ_ONCE          8'hff
`define APC_HX_FIRST_BIT     6
`define APC_HX_SECOND_BIT    7
`define APC_DECIM_BIT        3
`define APC_FLICKER_BIT      4
`endif

// ===== rtl/apc_window_mem.v
`timescale 1ns/1ps
// Eight-entry sample store for the proximity moving window; registered read
module apc_window_mem #(
  parameter DW = 10,
  parameter AW = 3
) (
  input  wire          clk_sys,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // apc_window_mem

// ===== rtl/apc_readout_config.v
`timescale 1ns/1ps
`include "apc_map.vh"
// Summary of operation
// R1: Three-bit field picks threshold light channel
// R2: Interval zero disables autozero entirely
// R3: Interval N autozeroes every N cycles
// R4: Interval 255 autozeroes once, first only
// R5: Each autozero resets light engine offsets
// R6: Both crosstalk bits give 10-bit output
// R7: Proximity average length is field plus one
// R8: Decimate bit checks once per n cycles
// R9: Flicker mode bit stored, read back
module apc_readout_config #(
  parameter PW = 10
) (
  input  wire          clk_sys,
  input  wire          resetn,
  input  wire          reg_wr,
  input  wire          reg_rd,
  input  wire [7:0]    reg_addr,
  input  wire [7:0]    reg_wdata,
  output reg  [7:0]    reg_rdata,
  input  wire          meas_start,
  input  wire          prox_valid,
  input  wire [PW-1:0] prox_sample,
  output reg  [2:0]    light_threshold_source_select,
  output reg           autozero_pulse,
  output reg           offset_reset,
  output reg           flicker_fifo_mode,
  output reg           high_crosstalk_active,
  output reg  [PW-1:0] prox_result,
  output reg           prox_result_valid,
  output reg           prox_check
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Byte-wide reset images, so single fields can be picked out of them
  localparam [7:0] RST_THRESH = `APC_RST_THRESH_SRC;
  localparam [7:0] RST_FLICK  = `APC_RST_FLICKER;
  localparam [7:0] RST_PROX   = `APC_RST_PROX_FILT;

  reg [2:0] thresh_src;
  reg [7:0] autozero_interval;
  reg       flicker_mode;
  reg       high_crosstalk_first_enable;
  reg       high_crosstalk_second_enable;
  reg       prox_average_decimate;
  reg [2:0] prox_average_length;
  reg       sched_restart;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      thresh_src                   <= RST_THRESH[2:0]; // R1
      autozero_interval            <= `APC_RST_AZ_SCHED; // R4
      flicker_mode                 <= RST_FLICK[`APC_FLICKER_BIT];
      high_crosstalk_first_enable  <= RST_PROX[`APC_HX_FIRST_BIT];
      high_crosstalk_second_enable <= RST_PROX[`APC_HX_SECOND_BIT];
      prox_average_decimate        <= RST_PROX[`APC_DECIM_BIT];
      prox_average_length          <= RST_PROX[2:0];
      sched_restart                <= 1'b0;
    end else begin
      sched_restart <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `APC_ADDR_THRESH_SRC: begin
            thresh_src <= reg_wdata[2:0]; // R1
          end
          `APC_ADDR_AZ_SCHED: begin
            autozero_interval <= reg_wdata;
            // Rewriting the schedule restarts its count and one-shot
            sched_restart     <= 1'b1;
          end
          `APC_ADDR_FLICKER: begin
            flicker_mode <= reg_wdata[`APC_FLICKER_BIT]; // R9
          end
          `APC_ADDR_PROX_FILT: begin
            high_crosstalk_second_enable <= reg_wdata[`APC_HX_SECOND_BIT];
            high_crosstalk_first_enable  <= reg_wdata[`APC_HX_FIRST_BIT];
            prox_average_decimate        <= reg_wdata[`APC_DECIM_BIT];
            prox_average_length          <= reg_wdata[2:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------
  // Read data registered; unmapped and reserved bits read zero
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `APC_ADDR_THRESH_SRC: next_rdata = {5'h00, thresh_src};
      `APC_ADDR_AZ_SCHED:   next_rdata = autozero_interval;
      `APC_ADDR_FLICKER:    next_rdata = {3'h0, flicker_mode, 4'h0}; // R9
      `APC_ADDR_PROX_FILT:  next_rdata = {high_crosstalk_second_enable,
                                          high_crosstalk_first_enable, 2'h0,
                                          prox_average_decimate, prox_average_length};
      default:              next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Autozero scheduler
  // ----------------------------------------------------------------
  reg [7:0] az_count;
  reg       az_once_done;
  reg       az_fire;
  always @* begin
    az_fire = 1'b0;
    if (autozero_interval == `APC_AZ_NEVER) begin
      az_fire = 1'b0; // R2
    end else if (autozero_interval == `APC_AZ_ONCE) begin
      az_fire = !az_once_done; // R4
    end else begin
      az_fire = (az_count == 8'h00); // R3
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      az_count       <= 8'h00;
      az_once_done   <= 1'b0;
      autozero_pulse <= 1'b0;
      offset_reset   <= 1'b0;
    end else begin
      autozero_pulse <= 1'b0;
      offset_reset   <= 1'b0;
      // A schedule rewrite beats a coinciding start, so the new
      // interval always counts from its own first measurement
      if (sched_restart) begin
        az_count     <= 8'h00;
        az_once_done <= 1'b0;
      end else if (meas_start) begin
        autozero_pulse <= az_fire;
        offset_reset   <= az_fire; // R5
        if (autozero_interval == `APC_AZ_ONCE) begin
          az_once_done <= 1'b1; // R4
        end
        // Count wraps at N-1 so cycle 0 of every N fires
        if (az_count >= autozero_interval - 8'h01) begin
          az_count <= 8'h00; // R3
        end else begin
          az_count <= az_count + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Static mode outputs
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      light_threshold_source_select <= 3'h0;
      flicker_fifo_mode             <= 1'b0;
      high_crosstalk_active         <= 1'b0;
    end else begin
      light_threshold_source_select <= thresh_src; // R1
      flicker_fifo_mode             <= flicker_mode; // R9
      high_crosstalk_active <= high_crosstalk_first_enable &
                               high_crosstalk_second_enable; // R6
    end
  end

  // ----------------------------------------------------------------
  // Proximity moving average
  // ----------------------------------------------------------------
  // In normal mode each sample keeps only its low 8 bits, with no saturation,
  // so the result is at most 8 bits and the upper two read zero
  wire [PW-1:0] sample_in = high_crosstalk_active ? prox_sample :
                            {{(PW-8){1'b0}}, prox_sample[7:0]}; // R6

  reg  [2:0]    wr_ptr;
  reg  [3:0]    fill;
  reg  [PW+2:0] acc;
  reg  [2:0]    decim_cnt;
  reg           stage;
  reg  [PW-1:0] stage_sample;
  reg  [2:0]    last_len;
  reg           last_decim;
  reg           last_hx;
  wire [PW-1:0] old_sample;
  wire [3:0]    win_len = {1'b0, prox_average_length} + 4'h1; // R7
  // The entry leaving the window was written n samples ago; it is read
  // one edge early so it is ready when the staged sample is summed
  wire [2:0]    oldest = wr_ptr - win_len[2:0];
  // Length, decimation or sample width changing makes the running sum
  // meaningless, so the window and the decimation phase start over
  wire          window_flush = (last_len != prox_average_length) ||
                               (last_decim != prox_average_decimate) ||
                               (last_hx != high_crosstalk_active);

  // ----------------------------------------------------------------
  // Window store
  // ----------------------------------------------------------------
  apc_window_mem #(
    .DW (PW),
    .AW (3)
  ) i_apc_window_mem (
    .clk_sys (clk_sys),
    .we      (prox_valid),
    .waddr   (wr_ptr),
    .wdata   (sample_in),
    .raddr   (oldest),
    .rdata   (old_sample)
  );

  // ----------------------------------------------------------------
  // Sample staging and change tracking
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_ptr       <= 3'h0;
      stage        <= 1'b0;
      stage_sample <= {PW{1'b0}};
      last_len     <= RST_PROX[2:0];
      last_decim   <= RST_PROX[`APC_DECIM_BIT];
      last_hx      <= 1'b0;
    end else begin
      stage      <= prox_valid;
      last_len   <= prox_average_length;
      last_decim <= prox_average_decimate;
      last_hx    <= high_crosstalk_active;
      if (prox_valid) begin
        stage_sample <= sample_in;
        wr_ptr       <= wr_ptr + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Running sum and result
  // ----------------------------------------------------------------
  // A plain divider; the divisor is at most 8 and the quotient only
  // has to settle within one clock, so no iterative unit is used
  function [PW-1:0] apc_div;
    input [PW+2:0] sum;
    input [3:0]    n;
    reg   [PW+2:0] quot;
    begin
      quot    = sum / {{(PW-1){1'b0}}, n};
      apc_div = quot[PW-1:0];
    end
  endfunction

  reg [PW+2:0] next_acc;
  always @* begin
    next_acc = acc + {3'h0, stage_sample};
    if (fill == win_len) begin
      next_acc = next_acc - {3'h0, old_sample};
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fill              <= 4'h0;
      acc               <= {(PW+3){1'b0}};
      decim_cnt         <= 3'h0;
      prox_result       <= {PW{1'b0}};
      prox_result_valid <= 1'b0;
      prox_check        <= 1'b0;
    end else begin
      prox_result_valid <= 1'b0;
      prox_check        <= 1'b0;
      if (window_flush) begin
        fill      <= 4'h0;
        acc       <= {(PW+3){1'b0}};
        decim_cnt <= 3'h0; // R8
      end else if (stage) begin
        acc <= next_acc;
        if (fill != win_len) begin
          fill <= fill + 4'h1;
        end
        if (!prox_average_decimate ||
            decim_cnt == prox_average_length) begin
          prox_result       <= apc_div(next_acc,
                                       (fill == win_len) ? win_len : fill + 4'h1); // R7
          prox_result_valid <= 1'b1; // R8
          prox_check        <= 1'b1; // R8
        end
        if (decim_cnt == prox_average_length) begin
          decim_cnt <= 3'h0; // R8
        end else begin
          decim_cnt <= decim_cnt + 3'h1;
        end
      end
    end
  end
endmodule // apc_readout_config

// ===== dv/apc_readout_config_asserts.sv
`timescale 1ns/1ps
module apc_checker (
  input logic       clk_sys,
  input logic       resetn,
  input logic       reg_wr,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       meas_start,
  input logic       prox_valid,
  input logic [2:0] light_threshold_source_select,
  input logic       autozero_pulse,
  input logic       offset_reset,
  input logic       flicker_fifo_mode,
  input logic       high_crosstalk_active,
  input logic       prox_result_valid,
  input logic       prox_check
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // Shadow of the interval, so the never case can be judged
  // ------------------------------------------------------------
  logic [7:0] az_q;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn) az_q <= 8'hff;
    else if (reg_wr && reg_addr == 8'ha4) az_q <= reg_wdata;
  property p_sel; reg_wr && reg_addr == 8'h9f |->
    ##2 light_threshold_source_select == $past(reg_wdata[2:0], 2); endproperty
  a_sel: assert property (p_sel) else $error("channel select wrong");
  property p_hx; reg_wr && reg_addr == 8'haa |->
    ##2 high_crosstalk_active == &$past(reg_wdata[7:6], 2); endproperty
  a_hx: assert property (p_hx) else $error("crosstalk mode wrong");
  property p_flk; reg_wr && reg_addr == 8'ha7 |->
    ##2 flicker_fifo_mode == $past(reg_wdata[4], 2); endproperty
  a_flk: assert property (p_flk) else $error("flicker mode wrong");
  property p_off; autozero_pulse == offset_reset; endproperty
  a_off: assert property (p_off) else $error("offset reset apart");
  property p_azc; autozero_pulse |-> $past(meas_start); endproperty
  a_azc: assert property (p_azc) else $error("autozero without start");
  property p_azn; autozero_pulse |-> $past(az_q) != 8'h00; endproperty
  a_azn: assert property (p_azn) else $error("autozero while never");
  property p_chk; prox_check == prox_result_valid; endproperty
  a_chk: assert property (p_chk) else $error("check apart from result");
  property p_pv; prox_result_valid |-> $past(prox_valid, 2); endproperty
  a_pv: assert property (p_pv) else $error("result without sample");
  c_az: cover property (autozero_pulse);
  c_pv: cover property (prox_result_valid && prox_check);
  c_hx: cover property (prox_result_valid && high_crosstalk_active);
endmodule // apc_checker
bind apc_readout_config apc_checker i_apc_checker (
  .clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .meas_start(meas_start), .prox_valid(prox_valid),
  .light_threshold_source_select(light_threshold_source_select),
  .autozero_pulse(autozero_pulse), .offset_reset(offset_reset),
  .flicker_fifo_mode(flicker_fifo_mode), .high_crosstalk_active(high_crosstalk_active),
  .prox_result_valid(prox_result_valid), .prox_check(prox_check));

// ===== dv/apc_host_model.sv
`timescale 1ns/1ps
module apc_host_model (
  input  logic       clk_sys,
  input  logic [7:0] reg_rdata,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  // Read data is taken a full cycle late; it holds until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask
endmodule // apc_host_model

// ===== dv/apc_readout_config_tb_top.sv
`timescale 1ns/1ps
module apc_readout_config_tb_top;
  logic       clk_sys, resetn, reg_wr, reg_rd, meas_start, prox_valid;
  logic       az_p, off_p, flk, hx, pv, chk;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [9:0] prox_sample, pr, pr_last;
  logic [2:0] sel;
  int         mismatches, checked, az_n, pv_n, off_n, chk_n;
  logic [7:0] ad[4] = '{8'h9f, 8'ha4, 8'ha7, 8'haa};
  logic [7:0] rv[4] = '{8'h00, 8'hff, 8'h00, 8'h00};
  logic [7:0] mk[4] = '{8'h07, 8'hff, 8'h10, 8'hcf};
  logic [7:0] av[4] = '{8'hff, 8'h00, 8'h03, 8'h01};
  int         ae[4] = '{1, 0, 3, 7};
  apc_readout_config i_apc_readout_config (.clk_sys(clk_sys), .resetn(resetn),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .meas_start(meas_start), .prox_valid(prox_valid),
    .prox_sample(prox_sample), .light_threshold_source_select(sel),
    .autozero_pulse(az_p), .offset_reset(off_p), .flicker_fifo_mode(flk),
    .high_crosstalk_active(hx), .prox_result(pr), .prox_result_valid(pv),
    .prox_check(chk));
  apc_host_model i_apc_host_model (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Pulses are counted on the falling edge, where they have settled
  always @(negedge clk_sys) begin
    if (az_p === 1'b1) az_n++;
    if (off_p === 1'b1) off_n++;
    if (chk === 1'b1) chk_n++;
    if (pv === 1'b1) begin
      pv_n++;
      pr_last = pr;
    end
  end
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic meas;
    @(negedge clk_sys) meas_start = 1'b1;
    @(negedge clk_sys) meas_start = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic prox_run(input logic [7:0] cfg, input logic [9:0] first, step,
                          input int cnt, input logic [9:0] ex, input int en);
    i_apc_host_model.wr(8'haa, cfg);
    repeat (2) @(negedge clk_sys);
    pv_n = 0;
    chk_n = 0;
    prox_sample = first;
    for (int i = 0; i < cnt; i++) begin
      @(negedge clk_sys) prox_valid = 1'b1;
      @(negedge clk_sys) prox_valid = 1'b0;
      prox_sample = prox_sample + step;
      repeat (2) @(negedge clk_sys);
    end
    repeat (3) @(negedge clk_sys);
    cmp(pr_last, ex);
    cmp(pv_n, en);
    cmp(chk_n, en);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    meas_start = 1'b0;
    prox_valid = 1'b0;
    prox_sample = 10'h000;
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      i_apc_host_model.rd(ad[i], d);
      cmp(d, rv[i]);
      i_apc_host_model.wr(ad[i], 8'hff);
      i_apc_host_model.rd(ad[i], d);
      cmp(d, mk[i]);
    end
    cmp(flk, 1'b1);
    i_apc_host_model.wr(8'ha5, 8'hff);
    i_apc_host_model.rd(8'ha5, d);
    cmp(d, 8'h00);
    for (int c = 0; c < 8; c++) begin
      i_apc_host_model.wr(8'h9f, c[7:0]);
      repeat (2) @(negedge clk_sys);
      cmp(sel, c[2:0]);
    end
    // Each write restarts the schedule, so every case counts from its own start
    for (int k = 0; k < 4; k++) begin
      i_apc_host_model.wr(8'ha4, av[k]);
      repeat (2) @(negedge clk_sys);
      az_n = 0;
      off_n = 0;
      repeat (7) meas;
      cmp(az_n, ae[k]);
      cmp(off_n, ae[k]);
    end
    prox_run(8'h01, 10'h00a, 10'h00a, 3, 10'h019, 3);
    prox_run(8'h0b, 10'h004, 10'h004, 8, 10'h01a, 2);
    prox_run(8'h00, 10'h3ff, 10'h000, 1, 10'h0ff, 1);
    prox_run(8'h40, 10'h3ff, 10'h000, 1, 10'h0ff, 1);
    prox_run(8'hc0, 10'h3ff, 10'h000, 1, 10'h3ff, 1);
    cmp(hx, 1'b1);
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    wrap_up;
  end
endmodule // apc_readout_config_tb_top
